// [design/ulpc_pkg.sv]
// constants and types for the usb link power and speed configuration block
package ulpc_pkg;
    localparam logic [7:0] ULPC_CFG0_OFFSET = 8'h80;
    localparam int ULPC_LINK_POWER_MGMT_CAPABLE_BIT = 30;
    localparam int ULPC_SUSP_BIT = 29;
    localparam int ULPC_THR_HI = 28;
    localparam int ULPC_THR_LO = 24;
    localparam int ULPC_BIN_HI = 23;
    localparam int ULPC_BIN_LO = 20;
    localparam int ULPC_BOUT_HI = 19;
    localparam int ULPC_BOUT_LO = 16;
    localparam int ULPC_SPD_HI = 15;
    localparam int ULPC_SPD_LO = 13;
    localparam int ULPC_OVL_BIT = 12;
    // bits 30:12 are implemented; 31 and 11:0 read as zero
    localparam logic [31:0] ULPC_WR_MASK = 32'h7fff_f000;
    // default: speed field at superspeed, everything else clear
    localparam logic [31:0] ULPC_CFG0_RESET = 32'h0000_8000;
    localparam logic [2:0] ULPC_SPEED_SS = 3'h4;
    localparam logic [2:0] ULPC_SPEED_HS = 3'h0;
    localparam logic [2:0] ULPC_SPEED_FS = 3'h1;
    localparam int ULPC_RESUME_BASE_US = 50;
    localparam int ULPC_RESUME_STEP_US = 75;
    localparam logic [1:0] ULPC_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] ULPC_HSIZE_WORD = 3'h2;

    typedef enum logic [1:0]
    {
        ULPC_L1_NONE = 2'b00,
        ULPC_L1_SLEEP = 2'b01,
        ULPC_L1_DEEP = 2'b10
    } ulpc_l1_mode_t;

    typedef enum logic [1:0]
    {
        ULPC_EX_IDLE = 2'b00,
        ULPC_EX_WAIT = 2'b01,
        ULPC_EX_DONE = 2'b10
    } ulpc_exit_state_t;

    // signalling time of a threshold or resume duration code in microseconds
    function automatic logic [10:0] ulpc_resume_us(input logic [3:0] code);
        ulpc_resume_us = 11'(ULPC_RESUME_BASE_US) + 11'(code) * 11'(ULPC_RESUME_STEP_US);
    endfunction
endpackage

// [design/ulpc_cfg_if.sv]
// carrier for the configuration fields from the register to the link logic
`timescale 1ns/1ns
interface ulpc_cfg_if;
    logic lpm_capable;
    logic suspend_allow;
    logic [4:0] resume_duration_threshold;
    logic exit_overlap_check_en;
    modport source (output lpm_capable, suspend_allow, resume_duration_threshold,
        exit_overlap_check_en);
    modport sink (input lpm_capable, suspend_allow, resume_duration_threshold,
        exit_overlap_check_en);
endinterface

// [design/ulpc_link_ctrl.sv]
// link power decisions: suspend gating, l1 phy mode and remote ux exit handshake
`timescale 1ns/1ns
module ulpc_link_ctrl
    import ulpc_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // configuration
    ulpc_cfg_if.sink cfg,
    // link side
    input wire logic lpm_request,
    input wire logic [3:0] host_resume_duration,
    input wire logic in_l1,
    input wire logic suspend_cond,
    input wire logic remote_exit_start,
    input wire logic remote_lfps_seen,
    input wire logic remote_ts_seen,
    output logic lpm_accept,
    output logic suspend_n,
    output logic phy_deep_lp,
    output logic phy_sleep,
    output logic exit_handshake_done
);
    ulpc_l1_mode_t l1_mode;
    ulpc_l1_mode_t next_l1_mode;
    ulpc_exit_state_t ex_state;
    ulpc_exit_state_t next_ex_state;
    logic next_suspend_n;
    logic next_lpm_accept;
    logic deep_ok;

    always_comb
    begin
        // compare signalling times so the encoding is kept in one place
        deep_ok = (ulpc_resume_us(host_resume_duration) >=
            ulpc_resume_us(cfg.resume_duration_threshold[3:0])) &&
            cfg.resume_duration_threshold[4];
        next_lpm_accept = lpm_request && cfg.lpm_capable;
        next_suspend_n = !(cfg.suspend_allow && suspend_cond);
        if (!in_l1)
            next_l1_mode = ULPC_L1_NONE;
        else if (deep_ok)
            next_l1_mode = ULPC_L1_DEEP;
        else
            next_l1_mode = ULPC_L1_SLEEP;
        next_ex_state = ex_state;
        case (ex_state)
            ULPC_EX_IDLE:
            begin
                if (remote_exit_start)
                begin
                    if (cfg.exit_overlap_check_en)
                        next_ex_state = ULPC_EX_WAIT;
                    else
                        next_ex_state = ULPC_EX_DONE;
                end
            end
            ULPC_EX_WAIT:
            begin
                if (remote_lfps_seen || remote_ts_seen)
                    next_ex_state = ULPC_EX_DONE;
            end
            ULPC_EX_DONE:
                next_ex_state = ULPC_EX_IDLE;
            default:
                next_ex_state = ULPC_EX_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            l1_mode <= ULPC_L1_NONE;
            ex_state <= ULPC_EX_IDLE;
            suspend_n <= 1'b1;
            lpm_accept <= 1'b0;
        end
        else
        begin
            l1_mode <= next_l1_mode;
            ex_state <= next_ex_state;
            suspend_n <= next_suspend_n;
            lpm_accept <= next_lpm_accept;
        end
    end

    assign phy_deep_lp = (l1_mode == ULPC_L1_DEEP);
    assign phy_sleep = (l1_mode == ULPC_L1_SLEEP);
    assign exit_handshake_done = (ex_state == ULPC_EX_DONE);
endmodule

// [design/ulpc_top.sv]
// ahb-lite register slave holding the usb configuration word and its link logic
`timescale 1ns/1ns
// Functional notes
// - lpm requests are accepted only while capability bit 30 is set
// - suspend_n asserts only when suspend_allow bit 29 is set and conditions hold
// - in l1 pick deep low-power when host duration >= threshold and bit 4 set
// - in l1 pick sleep when duration below threshold or bit 4 clear
// - threshold code zero is 50 us, each step adds 75 us
// - bulk-in burst limit is bits 23:20, packets minus one
// - bulk-out burst limit is bits 19:16, packets minus one
// - connect speed bits 15:13: 100 ss, 000 hs, 001 fs; resets to ss
// - overlap check set: remote exit waits for lfps or ts1/ts2 before done
// - overlap check clear: remote exit completes without overlap check
module ulpc_top
    import ulpc_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // configuration outputs
    output logic [3:0] bulk_in_burst_limit,
    output logic [3:0] bulk_out_burst_limit,
    output logic [2:0] connect_speed_select,
    output logic speed_is_super,
    output logic speed_is_high,
    output logic speed_is_full,
    // link side
    input wire logic lpm_request,
    input wire logic [3:0] host_resume_duration,
    input wire logic in_l1,
    input wire logic suspend_cond,
    input wire logic remote_exit_start,
    input wire logic remote_lfps_seen,
    input wire logic remote_ts_seen,
    output logic lpm_accept,
    output logic suspend_n,
    output logic phy_deep_lp,
    output logic phy_sleep,
    output logic exit_handshake_done
);
    logic [31:0] usb_config_zero;
    logic [31:0] next_usb_config_zero;
    logic wr_pend;
    logic next_wr_pend;
    logic [31:0] next_hrdata;
    logic hit;
    logic take;

    ulpc_cfg_if cfg_bus ();

    // address phase: single word transfers to the one mapped word
    assign take = hsel && hready && (htrans == ULPC_HTRANS_NONSEQ);
    assign hit = (haddr[7:0] == ULPC_CFG0_OFFSET) && (haddr[31:8] == 24'h00_0000) &&
        (hsize == ULPC_HSIZE_WORD);

    always_comb
    begin
        next_wr_pend = take && hwrite && hit;
        next_usb_config_zero = usb_config_zero;
        // write lands in the data phase; masked bits, including 31, stay zero
        if (wr_pend)
            next_usb_config_zero = hwdata & ULPC_WR_MASK;
        next_hrdata = hrdata;
        if (take && !hwrite)
            next_hrdata = hit ? (usb_config_zero & ULPC_WR_MASK) : 32'h0000_0000;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            usb_config_zero <= ULPC_CFG0_RESET;
            wr_pend <= 1'b0;
            hrdata <= 32'h0000_0000;
        end
        else
        begin
            usb_config_zero <= next_usb_config_zero;
            wr_pend <= next_wr_pend;
            hrdata <= next_hrdata;
        end
    end

    // zero wait states, always okay; unmapped reads return zero
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    assign bulk_in_burst_limit = usb_config_zero[ULPC_BIN_HI:ULPC_BIN_LO];
    assign bulk_out_burst_limit = usb_config_zero[ULPC_BOUT_HI:ULPC_BOUT_LO];
    assign connect_speed_select = usb_config_zero[ULPC_SPD_HI:ULPC_SPD_LO];
    // reserved speed codes select none of the three; limits above three pass as written
    assign speed_is_super = (connect_speed_select == ULPC_SPEED_SS);
    assign speed_is_high = (connect_speed_select == ULPC_SPEED_HS);
    assign speed_is_full = (connect_speed_select == ULPC_SPEED_FS);

    assign cfg_bus.lpm_capable = usb_config_zero[ULPC_LINK_POWER_MGMT_CAPABLE_BIT];
    assign cfg_bus.suspend_allow = usb_config_zero[ULPC_SUSP_BIT];
    assign cfg_bus.resume_duration_threshold = usb_config_zero[ULPC_THR_HI:ULPC_THR_LO];
    assign cfg_bus.exit_overlap_check_en = usb_config_zero[ULPC_OVL_BIT];

    ulpc_link_ctrl u_link
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .cfg(cfg_bus),
        .lpm_request(lpm_request),
        .host_resume_duration(host_resume_duration),
        .in_l1(in_l1),
        .suspend_cond(suspend_cond),
        .remote_exit_start(remote_exit_start),
        .remote_lfps_seen(remote_lfps_seen),
        .remote_ts_seen(remote_ts_seen),
        .lpm_accept(lpm_accept),
        .suspend_n(suspend_n),
        .phy_deep_lp(phy_deep_lp),
        .phy_sleep(phy_sleep),
        .exit_handshake_done(exit_handshake_done)
    );
endmodule

// [verification/ulpc_top_assertions.sv]
// bound checker on the configuration block's outputs
`timescale 1ns/1ns
module ulpc_top_assertions (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // register side
    input wire logic [31:0] hrdata,
    input wire logic [2:0] connect_speed_select,
    input wire logic speed_is_super,
    input wire logic speed_is_high,
    input wire logic speed_is_full,
    // link side
    input wire logic lpm_request,
    input wire logic in_l1,
    input wire logic suspend_cond,
    input wire logic remote_exit_start,
    input wire logic remote_lfps_seen,
    input wire logic remote_ts_seen,
    input wire logic lpm_accept,
    input wire logic suspend_n,
    input wire logic phy_deep_lp,
    input wire logic phy_sleep,
    input wire logic exit_handshake_done
);
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    sequence done_pulse;
        exit_handshake_done ##1 !exit_handshake_done;
    endsequence
    lpm_gate_a: assert property (lpm_accept |-> $past(lpm_request))
        else $error("accept without request");
    suspend_gate_a: assert property (!suspend_n |-> $past(suspend_cond))
        else $error("suspend without cause");
    deep_mode_a: assert property (phy_deep_lp |-> $past(in_l1) && !phy_sleep)
        else $error("deep mode outside l1");
    // the mode register is still held in reset at the release edge, so skip that cycle
    sleep_mode_a: assert property ($past(hresetn) && $past(in_l1) && !phy_deep_lp |->
        phy_sleep)
        else $error("no phy mode in l1");
    speed_decode_a: assert property ({speed_is_super, speed_is_high, speed_is_full} ==
        {connect_speed_select == 3'h4, connect_speed_select == 3'h0,
        connect_speed_select == 3'h1})
        else $error("speed decode wrong");
    exit_cause_a: assert property (exit_handshake_done |->
        $past(remote_exit_start || remote_lfps_seen || remote_ts_seen))
        else $error("exit done without cause");
    done_once_a: assert property (exit_handshake_done |-> done_pulse)
        else $error("exit done longer than a cycle");
    reserved_zero_a: assert property (hrdata[31] == 1'b0 && hrdata[11:0] == 12'h000)
        else $error("reserved bits not zero");
endmodule

bind ulpc_top ulpc_top_assertions u_chk (.hclk, .hresetn, .hrdata, .connect_speed_select,
    .speed_is_super, .speed_is_high, .speed_is_full, .lpm_request, .in_l1, .suspend_cond,
    .remote_exit_start, .remote_lfps_seen, .remote_ts_seen, .lpm_accept, .suspend_n,
    .phy_deep_lp, .phy_sleep, .exit_handshake_done);

// [verification/ulpc_host_model.sv]
// behavioural host controller on the link side
`timescale 1ns/1ns
module ulpc_host_model (
    // clock
    input wire logic hclk,
    // link toward the device
    output logic lpm_request,
    output logic [3:0] host_resume_duration,
    output logic in_l1,
    output logic suspend_cond,
    output logic remote_exit_start,
    output logic remote_lfps_seen,
    output logic remote_ts_seen
);
    initial
    begin
        {lpm_request, host_resume_duration, in_l1, suspend_cond} = 7'h00;
        {remote_exit_start, remote_lfps_seen, remote_ts_seen} = 3'h0;
    end
    task automatic drive(input logic lpm, input logic [3:0] dur, input logic l1, input logic sc);
        lpm_request <= lpm;
        host_resume_duration <= dur;
        in_l1 <= l1;
        suspend_cond <= sc;
    endtask
    task automatic kick();
        remote_exit_start <= 1'b1;
        @(posedge hclk);
        remote_exit_start <= 1'b0;
    endtask
    // overlap symbols only last one cycle, the harshest case for the device
    task automatic answer(input logic ts);
        remote_ts_seen <= ts;
        remote_lfps_seen <= !ts;
        @(posedge hclk);
        remote_ts_seen <= 1'b0;
        remote_lfps_seen <= 1'b0;
    endtask
endmodule

// [verification/usb_link_power_speed_config_tb.sv]
// self-checking bench for the usb link power and speed configuration block
`timescale 1ns/1ns
module usb_link_power_speed_config_tb
    import ulpc_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata, rd;
    logic hresp;
    logic hreadyout, lpm_request, in_l1, suspend_cond, remote_exit_start, remote_lfps_seen;
    logic remote_ts_seen, lpm_accept, suspend_n, phy_deep_lp, phy_sleep, exit_handshake_done;
    logic speed_is_super, speed_is_high, speed_is_full;
    logic [3:0] host_resume_duration, bulk_in_burst_limit, bulk_out_burst_limit;
    logic [2:0] connect_speed_select;
    int fail_count = 0;
    int cmp_count = 0;
    ulpc_top uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(ULPC_HSIZE_WORD),
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .bulk_in_burst_limit,
        .bulk_out_burst_limit, .connect_speed_select, .speed_is_super, .speed_is_high,
        .speed_is_full, .lpm_request, .host_resume_duration, .in_l1, .suspend_cond,
        .remote_exit_start, .remote_lfps_seen, .remote_ts_seen, .lpm_accept, .suspend_n,
        .phy_deep_lp, .phy_sleep, .exit_handshake_done);
    ulpc_host_model host (.hclk, .lpm_request, .host_resume_duration, .in_l1, .suspend_cond,
        .remote_exit_start, .remote_lfps_seen, .remote_ts_seen);
    initial forever #10 hclk = ~hclk;
    task automatic step(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // trailing idle cycle lets a direct check of the outputs see the word just written
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        haddr <= a;
        hwrite <= w;
        htrans <= ULPC_HTRANS_NONSEQ;
        hsel <= 1'b1;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        @(posedge hclk);
    endtask
    task automatic t_reg();
        logic [2:0] spd [4] = '{ULPC_SPEED_SS, ULPC_SPEED_HS, ULPC_SPEED_FS, 3'h7};
        ahb(1'b0, 32'h0000_0080, 32'h0000_0000);
        chk(rd, 32'h0000_8000);
        ahb(1'b1, 32'h0000_0080, 32'hffff_ffff);
        ahb(1'b1, 32'h0000_0084, 32'h0000_0000);
        ahb(1'b0, 32'h0000_0080, 32'h0000_0000);
        chk(rd, 32'h7fff_f000);
        ahb(1'b0, 32'h0000_0084, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        chk({hreadyout, hresp}, 2'b10);
        ahb(1'b1, 32'h0000_0080, 32'h0032_0000);
        chk({bulk_in_burst_limit, bulk_out_burst_limit}, 8'h32);
        foreach (spd[i])
        begin
            ahb(1'b1, 32'h0000_0080, {16'h0000, spd[i], 13'h0000});
            chk({connect_speed_select, speed_is_super, speed_is_high, speed_is_full},
                {spd[i], spd[i] == 3'h4, spd[i] == 3'h0, spd[i] == 3'h1});
        end
    endtask
    task automatic t_link();
        ahb(1'b1, 32'h0000_0080, 32'h2000_0000);
        host.drive(1'b1, 4'h3, 1'b0, 1'b1);
        step(2);
        chk({lpm_accept, suspend_n, phy_deep_lp, phy_sleep}, 4'h0);
        ahb(1'b1, 32'h0000_0080, 32'h5300_0000);
        host.drive(1'b1, 4'h3, 1'b1, 1'b1);
        step(2);
        chk({lpm_accept, suspend_n, phy_deep_lp, phy_sleep}, 4'he);
        host.drive(1'b0, 4'h2, 1'b1, 1'b0);
        step(2);
        chk({lpm_accept, suspend_n, phy_deep_lp, phy_sleep}, 4'h5);
        ahb(1'b1, 32'h0000_0080, 32'h4f00_0000);
        host.drive(1'b0, 4'hf, 1'b1, 1'b0);
        step(2);
        chk({phy_deep_lp, phy_sleep}, 2'b01);
    endtask
    // mid-run reset while the link stays in l1: outputs fall back, then follow the link again
    task automatic t_reset();
        hresetn <= 1'b0;
        step(2);
        chk({lpm_accept, suspend_n, phy_deep_lp, phy_sleep, exit_handshake_done,
            speed_is_super}, 6'h11);
        hresetn <= 1'b1;
        step(2);
        chk({phy_deep_lp, phy_sleep}, 2'b01);
        ahb(1'b0, 32'h0000_0080, 32'h0000_0000);
        chk(rd, 32'h0000_8000);
    endtask
    task automatic t_exit();
        ahb(1'b1, 32'h0000_0080, 32'h0000_0000);
        host.kick();
        step(1);
        chk(exit_handshake_done, 1'b1);
        step(1);
        chk(exit_handshake_done, 1'b0);
        ahb(1'b1, 32'h0000_0080, 32'h0000_1000);
        for (int i = 0; i < 2; i++)
        begin
            host.kick();
            step(3);
            chk(exit_handshake_done, 1'b0);
            host.answer(i[0]);
            step(1);
            chk(exit_handshake_done, 1'b1);
        end
    endtask
    task automatic end_sim();
        if (fail_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reg();
        t_link();
        t_reset();
        t_exit();
        end_sim();
    end
    initial
    begin
        #200000;
        fail_count++;
        end_sim();
    end
endmodule
